// ### mbpcd_decoder.sv
// parameter command decoder: dispatch, parameter store, exceptions, reply pacing
`include "mbpcd_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module mbpcd_decoder #(
   parameter int              IDX_N         = 16,
   parameter logic [15:0]     MAX_VAL       = 16'hffff,
   parameter logic [7:0]      PROT_GROUP    = 8'h0f,
   parameter int unsigned     RTU_GAP_CYC   = 32'(`MBPCD_RTU_GAP_CYC),
   parameter int unsigned     ASCII_GAP_CYC = 32'(`MBPCD_ASCII_GAP_CYC)
) (
   input  wire logic                 ref_clk,
   input  wire logic                 rst_n,
   input  wire logic                 req_valid,
   input  wire mbpcd_pkg::mbpcd_req_t req,
   input  wire logic                 param_lock,
   input  wire logic                 pw_ok,
   input  wire logic                 nv_busy,
   input  wire logic                 nv_fail,
   output logic                      req_ready,
   output logic                      rsp_valid,
   output mbpcd_pkg::mbpcd_rsp_t     rsp,
   output logic                      nv_req,
   output mbpcd_pkg::mbpcd_nv_t      nv
);
   localparam int NGRP = 23;
   default clocking dflt_cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   initial
      if (IDX_N < 1 || IDX_N > 256 || RTU_GAP_CYC < 1 || ASCII_GAP_CYC < 1)
         $error("mbpcd_decoder: unsupported parameter values");
   typedef enum logic [2:0] {
      S_IDLE = 3'b001,
      S_EXEC = 3'b010,
      S_GAP  = 3'b100
   } mbpcd_state_t;
   // group slot from high byte, NGRP when unmapped
   function automatic logic [4:0] grp_slot(input logic [7:0] g);
      if (g <= `MBPCD_GRP_LAST)
         grp_slot = g[4:0];
      else if (g == `MBPCD_GRP_CTRL)
         grp_slot = 5'd21;
      else if (g == `MBPCD_GRP_STAT)
         grp_slot = 5'd22;
      else
         grp_slot = 5'(NGRP);
   endfunction
   function automatic logic addr_ok(input logic [15:0] a);
      addr_ok = (grp_slot(a[15:8]) != 5'(NGRP)) && (32'(a[7:0]) < IDX_N);
   endfunction
   function automatic int unsigned mem_idx(input logic [15:0] a);
      mem_idx = 32'(grp_slot(a[15:8])) * 32'(IDX_N) + 32'(a[7:0]);
   endfunction
   logic [15:0]                 mem_q [NGRP*IDX_N];
   mbpcd_state_t                state_q, state_d;
   mbpcd_pkg::mbpcd_req_t       req_q, req_d;
   mbpcd_pkg::mbpcd_rsp_t       rsp_q, rsp_d;
   mbpcd_pkg::mbpcd_nv_t        nv_q, nv_d, pend_q, pend_d;
   logic                        rsp_valid_q, rsp_valid_d, nv_req_q, nv_req_d;
   logic                        pend_act_q, pend_act_d, silent_q, silent_d;
   logic                        ready_q, ready_d, wr_en;
   logic [31:0]                 gap_q, gap_d;
   logic [2:0]                  wr_cnt;
   // decode, execute and pace the reply
   always_comb
   begin
      logic [7:0]  exc;
      logic [2:0]  cnt;
      logic        is_wr;
      logic [15:0] a;
      exc         = 8'h00;
      cnt         = 3'd0;
      is_wr       = 1'b0;
      a           = 16'h0000;
      state_d     = state_q;
      req_d       = req_q;
      rsp_d       = rsp_q;
      nv_d        = nv_q;
      pend_d      = pend_q;
      pend_act_d  = pend_act_q && nv_busy;
      silent_d    = silent_q;
      ready_d     = ready_q;
      gap_d       = gap_q;
      rsp_valid_d = 1'b0;
      nv_req_d    = 1'b0;
      wr_en       = 1'b0;
      wr_cnt      = 3'd0;
      unique case (state_q)
         S_IDLE:
         begin
            if (req_valid && ready_q)
            begin
               req_d   = req;
               ready_d = 1'b0;
               state_d = S_EXEC;
            end
         end
         S_EXEC:
         begin
            rsp_d      = '0;
            rsp_d.func = req_q.func;
            rsp_d.addr = req_q.addr;
            rsp_d.word = req_q.word;
            if (req_q.frame_err)
               exc = `MBPCD_EX_FRAME;
            else
            begin
               unique case (req_q.func)
                  `MBPCD_FC_READ:
                  begin
                     if (req_q.word == 16'h0000 || req_q.word > 16'(`MBPCD_MAX_WORDS))
                        exc = `MBPCD_EX_DATA;
                     else
                     begin
                        cnt = req_q.word[2:0];
                        for (int i = 0; i < 4; i++)
                        begin
                           a = req_q.addr + 16'(i);
                           if (3'(i) < cnt && !addr_ok(a))
                              exc = `MBPCD_EX_ADDR;
                           else if (3'(i) < cnt)
                              rsp_d.data[i] = mem_q[mem_idx(a)];
                        end
                     end
                  end
                  `MBPCD_FC_WRITE1, `MBPCD_FC_WRITE1_NV, `MBPCD_FC_WRITEN:
                  begin
                     is_wr = 1'b1;
                     cnt   = (req_q.func == `MBPCD_FC_WRITEN) ? req_q.word[2:0] : 3'd1;
                     if (req_q.func == `MBPCD_FC_WRITEN &&
                         (req_q.word == 16'h0000 || req_q.word > 16'(`MBPCD_MAX_WORDS)))
                        exc = `MBPCD_EX_DATA;
                     for (int i = 0; i < 4; i++)
                     begin
                        a = req_q.addr + 16'(i);
                        if (exc == 8'h00 && 3'(i) < cnt)
                        begin
                           if (!addr_ok(a))
                              exc = `MBPCD_EX_ADDR;
                           else if (((req_q.func == `MBPCD_FC_WRITEN) ? req_q.data[i] : req_q.word) > MAX_VAL)
                              exc = `MBPCD_EX_DATA;
                           else if (param_lock && a[15:8] != `MBPCD_GRP_CTRL)
                              exc = `MBPCD_EX_LOCKED;
                           else if (a[15:8] == PROT_GROUP && !pw_ok)
                              exc = `MBPCD_EX_PASSWORD;
                        end
                     end
                     if (exc == 8'h00 && req_q.func == `MBPCD_FC_WRITE1_NV && pend_act_q &&
                         pend_q.addr == req_q.addr && pend_q.value == req_q.word)
                        exc = `MBPCD_EX_PENDING;
                     else if (exc == 8'h00 && nv_busy)
                        exc = `MBPCD_EX_BUSY;
                     else if (exc == 8'h00 && req_q.func == `MBPCD_FC_WRITE1_NV && nv_fail)
                        exc = `MBPCD_EX_FAIL;
                  end
                  `MBPCD_FC_DIAG:
                  begin
                     if (req_q.addr > `MBPCD_DIAG_SUB_MAX)
                        exc = `MBPCD_EX_DATA;
                  end
                  `MBPCD_FC_MANAGE:
                  begin
                     if (nv_busy)
                        exc = `MBPCD_EX_BUSY;
                  end
                  default:
                     exc = `MBPCD_EX_FUNC;
               endcase
            end
            if (exc != 8'h00)
            begin
               rsp_d.func   = req_q.func | `MBPCD_ERR_FLAG;
               rsp_d.code   = exc;
               rsp_d.nbytes = 5'd2;
            end
            else if (req_q.func == `MBPCD_FC_READ)
            begin
               rsp_d.code   = {4'h0, cnt, 1'b0};
               rsp_d.nbytes = 5'd2 + {1'b0, cnt, 1'b0};
            end
            else
               rsp_d.nbytes = 5'd5;
            rsp_d.nchars = req_q.ascii ? {rsp_d.nbytes, 1'b0} : {1'b0, rsp_d.nbytes};
            if (exc == 8'h00 && is_wr)
            begin
               wr_en  = 1'b1;
               wr_cnt = cnt;
               if (req_q.func == `MBPCD_FC_WRITE1_NV)
               begin
                  nv_req_d   = 1'b1;
                  nv_d       = '{addr: req_q.addr, value: req_q.word};
                  pend_d     = nv_d;
                  pend_act_d = 1'b1;
               end
            end
            silent_d = req_q.broadcast;
            gap_d    = req_q.ascii ? ASCII_GAP_CYC - 32'd1 : RTU_GAP_CYC - 32'd1;
            state_d  = S_GAP;
         end
         S_GAP:
         begin
            if (gap_q == 32'd0)
            begin
               rsp_valid_d = !silent_q;
               ready_d     = 1'b1;
               state_d     = S_IDLE;
            end
            else
               gap_d = gap_q - 32'd1;
         end
      endcase
   end
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q     <= S_IDLE;
         req_q       <= '0;
         rsp_q       <= '0;
         nv_q        <= '0;
         pend_q      <= '0;
         pend_act_q  <= 1'b0;
         silent_q    <= 1'b0;
         ready_q     <= 1'b1;
         gap_q       <= 32'd0;
         rsp_valid_q <= 1'b0;
         nv_req_q    <= 1'b0;
      end
      else
      begin
         state_q     <= state_d;
         req_q       <= req_d;
         rsp_q       <= rsp_d;
         nv_q        <= nv_d;
         pend_q      <= pend_d;
         pend_act_q  <= pend_act_d;
         silent_q    <= silent_d;
         ready_q     <= ready_d;
         gap_q       <= gap_d;
         rsp_valid_q <= rsp_valid_d;
         nv_req_q    <= nv_req_d;
      end
   end
   // parameter store, volatile
   always_ff @(posedge ref_clk)
   begin
      for (int i = 0; i < 4; i++)
         if (wr_en && 3'(i) < wr_cnt)
            mem_q[mem_idx(req_q.addr + 16'(i))] <=
               (req_q.func == `MBPCD_FC_WRITEN) ? req_q.data[i] : req_q.word;
   end
   assign req_ready = ready_q;
   assign rsp_valid = rsp_valid_q;
   assign rsp       = rsp_q;
   assign nv_req    = nv_req_q;
   assign nv        = nv_q;
   property p_bad_func;
      (state_q == S_EXEC && !req_q.frame_err && !(req_q.func inside {8'h03, 8'h06, 8'h08, 8'h10, 8'h41, 8'h42}))
      |=> rsp_q.code == 8'h01;
   endproperty
   a_bad_func: assert property (p_bad_func) else $error("unsupported function not coded 1");
   property p_err_func;
      (state_q == S_EXEC) |=> (rsp_q.func[7] == (rsp_q.nbytes == 5'd2 && req_q.func[7] == 1'b0
                               && rsp_q.func != req_q.func)) || req_q.func[7];
   endproperty
   a_err_func: assert property (p_err_func) else $error("error function flag mismatch");
   property p_frame;
      (state_q == S_EXEC && req_q.frame_err) |=> rsp_q.code == 8'h18 && rsp_q.func == ($past(req_q.func) | 8'h80);
   endproperty
   a_frame: assert property (p_frame) else $error("frame error not coded 18");
   property p_read_cnt;
      (state_q == S_EXEC && !req_q.frame_err && req_q.func == 8'h03 && req_q.word > 16'd4)
      |=> rsp_q.code == 8'h03 && rsp_q.func == 8'h83;
   endproperty
   a_read_cnt: assert property (p_read_cnt) else $error("bad read count not coded 3");
   property p_read_len;
      (rsp_valid_q && rsp_q.func == 8'h03) |-> rsp_q.nbytes == rsp_q.code[4:0] + 5'd2 && rsp_q.code[0] == 1'b0;
   endproperty
   a_read_len: assert property (p_read_len) else $error("read byte count wrong");
   property p_ascii_len;
      (state_q == S_EXEC && req_q.ascii) |=> rsp_q.nchars == {rsp_q.nbytes, 1'b0};
   endproperty
   a_ascii_len: assert property (p_ascii_len) else $error("ascii length not doubled");
   // request stays held through the gap, so the last gap cycle is covered too
   property p_bcast;
      (state_q == S_GAP && req_q.broadcast) |=> !rsp_valid_q;
   endproperty
   a_bcast: assert property (p_bcast) else $error("broadcast request answered");
   property p_gap;
      (state_q == S_EXEC) |=> !rsp_valid_q [*2];
   endproperty
   a_gap: assert property (p_gap) else $error("reply sent before idle gap");
   property p_nv_busy;
      (state_q == S_EXEC && !req_q.frame_err && req_q.func == 8'h06 && nv_busy && addr_ok(req_q.addr)
       && !param_lock && req_q.addr[15:8] != PROT_GROUP && req_q.word <= MAX_VAL)
      |=> rsp_q.code == 8'h06 && !nv_req_q;
   endproperty
   a_nv_busy: assert property (p_nv_busy) else $error("busy store not coded 6");
   property p_nv_commit;
      nv_req_q |-> $past(req_q.func) == 8'h41 && nv_q.value == $past(req_q.word) && rsp_q.code == 8'h00;
   endproperty
   a_nv_commit: assert property (p_nv_commit) else $error("commit without accepted store write");
   property p_volatile;
      (state_q == S_EXEC && req_q.func inside {8'h06, 8'h10}) |=> !nv_req_q;
   endproperty
   a_volatile: assert property (p_volatile) else $error("volatile write committed");
   c_read: cover property (@(posedge ref_clk) disable iff (!rst_n) rsp_valid_q && rsp_q.func == 8'h03);
   c_commit: cover property (@(posedge ref_clk) disable iff (!rst_n) nv_req_q);
   c_pending: cover property (@(posedge ref_clk) disable iff (!rst_n) rsp_valid_q && rsp_q.code == 8'h05);
   c_error: cover property (@(posedge ref_clk) disable iff (!rst_n) rsp_valid_q && rsp_q.func[7]);
endmodule // mbpcd_decoder
`default_nettype wire

// ### mbpcd_defines.svh
// constants for the parameter command decoder
`ifndef MBPCD_DEFINES_SVH
`define MBPCD_DEFINES_SVH
`define MBPCD_FC_READ      8'h03
`define MBPCD_FC_WRITE1    8'h06
`define MBPCD_FC_DIAG      8'h08
`define MBPCD_FC_WRITEN    8'h10
`define MBPCD_FC_WRITE1_NV 8'h41
`define MBPCD_FC_MANAGE    8'h42
`define MBPCD_ERR_FLAG     8'h80
`define MBPCD_EX_FUNC      8'h01
`define MBPCD_EX_ADDR      8'h02
`define MBPCD_EX_DATA      8'h03
`define MBPCD_EX_FAIL      8'h04
`define MBPCD_EX_PENDING   8'h05
`define MBPCD_EX_BUSY      8'h06
`define MBPCD_EX_FRAME     8'h18
`define MBPCD_EX_LOCKED    8'h20
`define MBPCD_EX_PASSWORD  8'h22
`define MBPCD_GRP_FIRST    8'h00
`define MBPCD_GRP_LAST     8'h14
`define MBPCD_GRP_CTRL     8'h32
`define MBPCD_GRP_STAT     8'h33
`define MBPCD_MAX_WORDS    3'd4
`define MBPCD_DIAG_SUB_MAX 16'h0030
`define MBPCD_CLK_HZ       64'd40000000
`define MBPCD_BAUD         64'd19200
`define MBPCD_BITS_CHAR    64'd11
// 3.5 characters, tenths of a character
`define MBPCD_RTU_GAP_TENTHS 64'd35
`define MBPCD_ASCII_GAP_NS   64'd1000000
`define MBPCD_CLK_NS         64'd25
// least times: round up
`define MBPCD_RTU_GAP_CYC ((`MBPCD_RTU_GAP_TENTHS*`MBPCD_BITS_CHAR*`MBPCD_CLK_HZ + 64'd10*`MBPCD_BAUD - 64'd1) \
                           / (64'd10*`MBPCD_BAUD))
`define MBPCD_ASCII_GAP_CYC ((`MBPCD_ASCII_GAP_NS + `MBPCD_CLK_NS - 64'd1) / `MBPCD_CLK_NS)
`endif

// ### mbpcd_master_model.sv
// modbus master station model: offers one request, collects its reply
`timescale 1ns/1ps
`default_nettype none
module mbpcd_master_model (
   input  wire logic                  ref_clk,
   input  wire logic                  req_ready,
   input  wire logic                  rsp_valid,
   input  wire mbpcd_pkg::mbpcd_rsp_t rsp,
   output var logic                   req_valid,
   output var mbpcd_pkg::mbpcd_req_t  req
);
   initial
   begin
      req_valid = 1'b0;
      req       = '0;
   end

   // one request at a time, held until taken; unit sizes as framed
   task automatic xfer(input mbpcd_pkg::mbpcd_req_t r, output mbpcd_pkg::mbpcd_rsp_t got, output int lat);
      int n;
      n = 0;
      @(negedge ref_clk);
      req_valid = 1'b1;
      req       = r;
      // ready looked at where settled; the next rising edge takes the request
      while (req_ready !== 1'b1 && n < 100)
      begin
         n++;
         @(negedge ref_clk);
      end
      @(posedge ref_clk);
      @(negedge ref_clk);
      req_valid = 1'b0;
      // released bus shows no stale request
      req       = ~r;
      lat       = 1;
      // 200 means no reply came
      while (rsp_valid !== 1'b1 && lat < 200)
      begin
         lat++;
         @(negedge ref_clk);
      end
      got = rsp;
   endtask
endmodule // mbpcd_master_model
`default_nettype wire

// ### mbpcd_pkg.sv
// types shared by the parameter command decoder
package mbpcd_pkg;
   typedef struct packed {
      logic              frame_err;
      logic              broadcast;
      logic              ascii;
      logic [7:0]        func;
      logic [15:0]       addr;
      logic [15:0]       word;
      logic [3:0][15:0]  data;
   } mbpcd_req_t;

   typedef struct packed {
      logic [7:0]        func;
      logic [7:0]        code;
      logic [15:0]       addr;
      logic [15:0]       word;
      logic [3:0][15:0]  data;
      logic [4:0]        nbytes;
      logic [5:0]        nchars;
   } mbpcd_rsp_t;

   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] value;
   } mbpcd_nv_t;
endpackage

// ### tb_modbus_parameter_command_decoder.sv
// testbench for the parameter command decoder
`timescale 1ns/1ps
`default_nettype none
module tb_modbus_parameter_command_decoder;
   localparam int unsigned RTU_G = 8;
   localparam int unsigned ASC_G = 4;
   logic                  ref_clk;
   logic                  rst_n;
   logic                  param_lock;
   logic                  pw_ok;
   logic                  nv_busy;
   logic                  nv_fail;
   logic                  req_valid;
   logic                  req_ready;
   logic                  rsp_valid;
   logic                  nv_req;
   mbpcd_pkg::mbpcd_req_t req;
   mbpcd_pkg::mbpcd_rsp_t rsp;
   mbpcd_pkg::mbpcd_rsp_t got;
   mbpcd_pkg::mbpcd_nv_t  nv;
   logic [3:0][15:0]      wd;
   int                    fails;
   int                    comparisons;
   int                    lat;
   int                    nv_pulses;

   mbpcd_decoder #(.RTU_GAP_CYC(RTU_G), .ASCII_GAP_CYC(ASC_G)) i_dut (
      .ref_clk(ref_clk), .rst_n(rst_n), .req_valid(req_valid), .req(req), .param_lock(param_lock),
      .pw_ok(pw_ok), .nv_busy(nv_busy), .nv_fail(nv_fail), .req_ready(req_ready),
      .rsp_valid(rsp_valid), .rsp(rsp), .nv_req(nv_req), .nv(nv));

   mbpcd_master_model i_master (
      .ref_clk(ref_clk), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp),
      .req_valid(req_valid), .req(req));

   initial
   begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   // store model: counts commits, reports busy from the falling edge that sees one
   always @(negedge ref_clk)
      if (nv_req === 1'b1)
      begin
         nv_pulses++;
         nv_busy = 1'b1;
      end

   task automatic complete_run();
      $display("comparisons %0d, fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
      comparisons++;
      if (seen !== exp)
      begin
         fails++;
         $display("wrong value %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   task automatic op(input logic [7:0] f, input logic [15:0] a, input logic [15:0] w,
                     input logic asc = 1'b0, input logic bc = 1'b0, input logic fe = 1'b0);
      mbpcd_pkg::mbpcd_req_t q;
      q           = '0;
      q.func      = f;
      q.addr      = a;
      q.word      = w;
      q.data      = wd;
      q.ascii     = asc;
      q.broadcast = bc;
      q.frame_err = fe;
      i_master.xfer(q, got, lat);
   endtask

   task automatic t_read_write();
      int p0;
      p0 = nv_pulses;
      wd = '0;
      op(8'h06, 16'h0302, 16'h0fa0);
      chk("write reply", {8'h06, 8'h00}, {got.func, got.code});
      chk("write echo addr", 16'h0302, got.addr);
      chk("write echo value", 16'h0fa0, got.word);
      chk("rtu delay", 16'(RTU_G + 2), 16'(lat));
      chk("no commit", 16'(p0), 16'(nv_pulses));
      op(8'h03, 16'h0302, 16'h0001);
      chk("read reply", {8'h03, 8'h02}, {got.func, got.code});
      chk("read word", 16'h0fa0, got.data[0]);
      chk("read bytes", 16'd4, 16'(got.nbytes));
      $display("test read_write done");
   endtask

   task automatic t_multi();
      int p0;
      p0 = nv_pulses;
      wd = {16'h4444, 16'h3333, 16'h2222, 16'h1111};
      op(8'h10, 16'h1400, 16'h0004, 1'b1);
      chk("multi reply", {8'h10, 8'h00}, {got.func, got.code});
      chk("ascii delay", 16'(ASC_G + 2), 16'(lat));
      chk("ascii chars", 16'd10, 16'(got.nchars));
      chk("no commit", 16'(p0), 16'(nv_pulses));
      wd = '0;
      op(8'h03, 16'h1400, 16'h0004, 1'b1);
      chk("read count", {8'h03, 8'h08}, {got.func, got.code});
      chk("ascii chars", 16'd20, 16'(got.nchars));
      for (int i = 0; i < 4; i++)
         chk("multi word", 16'(16'h1111 * (i + 1)), got.data[i]);
      $display("test multi done");
   endtask

   task automatic t_groups();
      logic [15:0] good[4] = '{16'h0000, 16'h140f, 16'h3201, 16'h3300};
      logic [15:0] bad[4]  = '{16'h1500, 16'h3100, 16'h3400, 16'h0010};
      for (int i = 0; i < 4; i++)
      begin
         op(8'h06, good[i], 16'(16'h5a00 + i));
         chk("group write", {8'h06, 8'h00}, {got.func, got.code});
         op(8'h03, good[i], 16'h0001);
         chk("group read", 16'(16'h5a00 + i), got.data[0]);
         op(8'h06, bad[i], 16'h0001);
         chk("bad address", {8'h86, 8'h02}, {got.func, got.code});
         chk("error bytes", 16'd2, 16'(got.nbytes));
      end
      $display("test groups done");
   endtask

   task automatic t_funcs();
      logic [7:0] bad[5] = '{8'h01, 8'h04, 8'h05, 8'h43, 8'h11};
      for (int i = 0; i < 5; i++)
      begin
         op(bad[i], 16'h0000, 16'h0001);
         chk("bad function", {bad[i] | 8'h80, 8'h01}, {got.func, got.code});
      end
      op(8'h08, 16'h0030, 16'h1234);
      chk("diag reply", {8'h08, 8'h00}, {got.func, got.code});
      chk("diag echo", 16'h1234, got.word);
      op(8'h08, 16'h0031, 16'h0000);
      chk("diag range", {8'h88, 8'h03}, {got.func, got.code});
      op(8'h42, 16'h0000, 16'h0000);
      chk("manage reply", {8'h42, 8'h00}, {got.func, got.code});
      $display("test funcs done");
   endtask

   task automatic t_range();
      op(8'h03, 16'h0000, 16'h0000);
      chk("count zero", {8'h83, 8'h03}, {got.func, got.code});
      op(8'h03, 16'h0000, 16'h0005);
      chk("count five", {8'h83, 8'h03}, {got.func, got.code});
      op(8'h03, 16'h0000, 16'h0001, 1'b0, 1'b0, 1'b1);
      chk("frame error", {8'h83, 8'h18}, {got.func, got.code});
      op(8'h06, 16'h0001, 16'h0007, 1'b0, 1'b1);
      chk("broadcast silent", 16'd200, 16'(lat));
      $display("test range done");
   endtask

   task automatic t_nv();
      int p0;
      p0 = nv_pulses;
      op(8'h41, 16'h0105, 16'h0077);
      chk("commit reply", {8'h41, 8'h00}, {got.func, got.code});
      chk("commit pulse", 16'(p0 + 1), 16'(nv_pulses));
      chk("commit addr", 16'h0105, nv.addr);
      chk("commit value", 16'h0077, nv.value);
      nv_busy = 1'b1;
      op(8'h41, 16'h0105, 16'h0077);
      chk("pending", {8'hc1, 8'h05}, {got.func, got.code});
      op(8'h06, 16'h0001, 16'h0001);
      chk("busy", {8'h86, 8'h06}, {got.func, got.code});
      nv_busy = 1'b0;
      op(8'h06, 16'h0001, 16'h0001);
      chk("retry", {8'h06, 8'h00}, {got.func, got.code});
      nv_fail = 1'b1;
      op(8'h41, 16'h0002, 16'h0003);
      chk("store fails", {8'hc1, 8'h04}, {got.func, got.code});
      nv_fail = 1'b0;
      $display("test nv done");
   endtask

   task automatic t_protect();
      param_lock = 1'b1;
      op(8'h06, 16'h0001, 16'h0005);
      chk("locked", {8'h86, 8'h20}, {got.func, got.code});
      op(8'h06, 16'h3201, 16'h0005);
      chk("control unlocked", {8'h06, 8'h00}, {got.func, got.code});
      param_lock = 1'b0;
      pw_ok      = 1'b0;
      op(8'h06, 16'h0f01, 16'h0005);
      chk("password", {8'h86, 8'h22}, {got.func, got.code});
      op(8'h06, 16'h0e01, 16'h0005);
      chk("unprotected", {8'h06, 8'h00}, {got.func, got.code});
      pw_ok = 1'b1;
      $display("test protect done");
   endtask

   initial
   begin
      fails       = 0;
      comparisons = 0;
      nv_pulses   = 0;
      wd          = '0;
      rst_n       = 1'b0;
      param_lock  = 1'b0;
      pw_ok       = 1'b1;
      nv_busy     = 1'b0;
      nv_fail     = 1'b0;
      repeat (20) @(negedge ref_clk);
      chk("ready in reset", 16'h0001, {15'h0000, req_ready});
      rst_n = 1'b1;
      t_read_write();
      t_multi();
      t_groups();
      t_funcs();
      t_range();
      t_nv();
      t_protect();
      complete_run();
   end

   initial
   begin
      repeat (20000) @(posedge ref_clk);
      fails++;
      $display("watchdog expired");
      complete_run();
   end
endmodule // tb_modbus_parameter_command_decoder
`default_nettype wire
